// File: rtl/pdc_pkg.sv
// Function
// - With separate reference clocks the block sends the fast-training count in bits 31:24, which resets to 32h.
// - With a shared reference clock the block sends the fast-training count in bits 23:16, which resets to 14h.
// - Bit 7 lets the block apply L2 power savings only while it reads 1.
// - Bit 6 enables the base window at configuration offset 14h and resets to 0.
// - Bit 5 enables the base window at configuration offset 10h and resets to 0.
// - Bits 4 to 0 drive recovery, reconfigure, hot reset, scrambler off and loopback requests to link training.
// - The fast-training counts and link number return to 32h, 14h and 0 only on the active-low fundamental reset.
package pdc_pkg;
    // Register placement in configuration space
    localparam int          CFG_ADDR_W     = 8;
    localparam logic [7:0]  DIAG_TWO_OFF   = 8'hC8;
    localparam logic [31:0] DIAG_TWO_RST   = 32'h3214_2000;

    // Field positions and widths
    localparam int FTS_W          = 8;
    localparam int FTS_SEP_LSB    = 24;
    localparam int FTS_SHARED_LSB = 16;
    localparam int REV_W          = 3;
    localparam int REV_LSB        = 13;
    localparam int LINK_W         = 5;
    localparam int LINK_LSB       = 8;
    localparam int L2_BIT         = 7;
    localparam int WIN1_BIT       = 6;
    localparam int WIN0_BIT       = 5;
    localparam int TRN_W          = 5;
    localparam int TRN_LSB        = 0;

    // Request positions inside the training request field
    localparam int TRN_LOOPBACK_IDX  = 0;
    localparam int TRN_SCRAMBLER_IDX = 1;
    localparam int TRN_HOT_RESET_IDX = 2;
    localparam int TRN_RECONFIG_IDX  = 3;
    localparam int TRN_RECOVERY_IDX  = 4;

    // Values after reset
    localparam logic [FTS_W-1:0]  FTS_SEP_RST    = 8'h32;
    localparam logic [FTS_W-1:0]  FTS_SHARED_RST = 8'h14;
    localparam logic [REV_W-1:0]  PHY_REVISION_FIELD_VALUE  = 3'h1;
    localparam logic [LINK_W-1:0] LINK_RST       = 5'h00;
    localparam logic [TRN_W-1:0]  TRN_RST        = 5'h00;
endpackage : pdc_pkg

// File: rtl/pdc_cfg_if.sv
// Decoded configuration access between the access port and the register core
interface pdc_cfg_if;
    logic        wr_en;
    logic        rd_hit;
    logic [31:0] wr_mask;
    logic [31:0] wr_data;
    logic [31:0] reg_value;

    modport port (output wr_en, output rd_hit, output wr_mask, output wr_data, input reg_value);
    modport core (input wr_en, input rd_hit, input wr_mask, input wr_data, output reg_value);
endinterface : pdc_cfg_if

// File: rtl/pdc_cfg_port.sv
// Configuration access port: decodes the dword, answers one cycle later
module pdc_cfg_port #(
    parameter int ADDR_W = pdc_pkg::CFG_ADDR_W
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Configuration request
    input  wire logic              req,
    input  wire logic              write,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [3:0]        byte_en,
    input  wire logic [31:0]       wdata,
    // Answer
    output logic                   ack,
    output logic [31:0]            rdata,
    // Decoded side towards the core
    pdc_cfg_if.port                cfg
);
    import pdc_pkg::*;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } pdc_port_state_t;

    pdc_port_state_t st;
    pdc_port_state_t next_st;
    logic            hit;

    // Offset must be reachable with the chosen address width
    if (ADDR_W < 8) begin : g_addr_check
        $error("pdc_cfg_port: ADDR_W below 8 cannot reach the register");
    end

    // Dword match; the low two address bits are don't care
    assign hit         = req && (addr[7:2] == DIAG_TWO_OFF[7:2]) && ((addr >> 8) == '0); // Upper bits clear
    assign cfg.wr_en   = hit && write;
    assign cfg.rd_hit  = hit && !write;
    assign cfg.wr_data = wdata;

    // Byte enables widen to a bit mask
    for (genvar b = 0; b < 4; b++) begin : g_mask
        assign cfg.wr_mask[8*b +: 8] = {8{byte_en[b]}};
    end

    // Every request is answered; unmapped reads return zero
    always_comb begin
        next_st       = st;
        next_st.ack   = req;
        next_st.rdata = cfg.rd_hit ? cfg.reg_value : 32'h0000_0000;
        if (!rst_n) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

    assign ack   = st.ack;
    assign rdata = st.rdata;
endmodule : pdc_cfg_port

// File: rtl/pdc_top.sv
// PHY diagnostic and control register two with its steering outputs
module pdc_top (
    // Clock and resets
    input  wire logic                         CLOCK,
    input  wire logic                         RST_N,
    input  wire logic                         FUNDAMENTAL_RESET_N,
    // Configuration access
    input  wire logic                         CFG_REQ,
    input  wire logic                         CFG_WRITE,
    input  wire logic [pdc_pkg::CFG_ADDR_W-1:0] CFG_ADDR,
    input  wire logic [3:0]                   CFG_BYTE_EN,
    input  wire logic [31:0]                  CFG_WDATA,
    output logic                              CFG_ACK,
    output logic [31:0]                       CFG_RDATA,
    // Link state from the rest of the bridge
    input  wire logic                         SHARED_REFCLK_CONFIG,
    input  wire logic                         LINK_IN_L2,
    // Steering outputs
    output logic [pdc_pkg::FTS_W-1:0]         FAST_TRAIN_COUNT,
    output logic                              L2_POWER_SAVE,
    output logic                              FIRST_BASE_WINDOW_ENABLE,
    output logic                              SECOND_BASE_WINDOW_ENABLE,
    output logic [pdc_pkg::LINK_W-1:0]        LINK_NUMBER,
    // Requests into link training
    output logic                              TRAINING_RECOVERY_REQUEST,
    output logic                              TRAINING_RECONFIGURE_REQUEST,
    output logic                              HOT_RESET_REQUEST,
    output logic                              SCRAMBLER_OFF_REQUEST,
    output logic                              TRAINING_LOOPBACK_REQUEST
);
    import pdc_pkg::*;

    typedef struct packed {
        logic [FTS_W-1:0]  fast_train_count_separate_clock;
        logic [FTS_W-1:0]  fast_train_count_shared_clock;
        logic [LINK_W-1:0] link_number;
        logic              l2_power_saving_enable;
        logic              second_base_window_enable;
        logic              first_base_window_enable;
        logic [TRN_W-1:0]  train_req;
        // Registered copies that drive the ports
        logic [FTS_W-1:0]  fts_out;
        logic              l2_save_out;
        logic              win0_out;
        logic              win1_out;
        logic [LINK_W-1:0] link_out;
        logic [TRN_W-1:0]  trn_out;
    } pdc_state_t;

    pdc_state_t  st;
    pdc_state_t  next_st;
    logic [31:0] merged;
    pdc_cfg_if   cfg ();

    // Access port answers every request one cycle later
    pdc_cfg_port #(
        .ADDR_W (CFG_ADDR_W)
    ) u_port (
        .clock   (CLOCK),
        .rst_n   (RST_N),
        .req     (CFG_REQ),
        .write   (CFG_WRITE),
        .addr    (CFG_ADDR),
        .byte_en (CFG_BYTE_EN),
        .wdata   (CFG_WDATA),
        .ack     (CFG_ACK),
        .rdata   (CFG_RDATA),
        .cfg     (cfg)
    );

    // Read image of the register
    // fixed revision field
    assign cfg.reg_value = {st.fast_train_count_separate_clock,
                            st.fast_train_count_shared_clock,
                            PHY_REVISION_FIELD_VALUE,
                            st.link_number,
                            st.l2_power_saving_enable,
                            st.second_base_window_enable,
                            st.first_base_window_enable,
                            st.train_req};

    // Byte-lane merge of a write with the current contents
    assign merged = (cfg.reg_value & ~cfg.wr_mask) | (cfg.wr_data & cfg.wr_mask);

    // Field updates, output staging and the two reset scopes
    always_comb begin
        next_st = st;
        // A write that meets an ordinary reset is dropped, so the kept fields stay intact
        if (cfg.wr_en && RST_N) begin
            next_st.fast_train_count_separate_clock = merged[FTS_SEP_LSB +: FTS_W];
            next_st.fast_train_count_shared_clock   = merged[FTS_SHARED_LSB +: FTS_W];
            next_st.link_number               = merged[LINK_LSB +: LINK_W];
            next_st.l2_power_saving_enable    = merged[L2_BIT];
            next_st.second_base_window_enable = merged[WIN1_BIT];
            next_st.first_base_window_enable  = merged[WIN0_BIT];
            next_st.train_req                 = merged[TRN_LSB +: TRN_W];
        end
        next_st.fts_out     = SHARED_REFCLK_CONFIG ? st.fast_train_count_shared_clock
                                                   : st.fast_train_count_separate_clock;
        next_st.l2_save_out = st.l2_power_saving_enable && LINK_IN_L2;
        next_st.win1_out    = st.second_base_window_enable;
        next_st.win0_out    = st.first_base_window_enable;
        next_st.link_out    = st.link_number;
        next_st.trn_out     = st.train_req;
        // Ordinary reset leaves the counts and link number alone
        if (!RST_N) begin
            next_st.l2_power_saving_enable    = 1'b0;
            next_st.second_base_window_enable = 1'b0;
            next_st.first_base_window_enable  = 1'b0;
            next_st.train_req                 = TRN_RST;
            next_st.l2_save_out               = 1'b0;
            next_st.win0_out                  = 1'b0;
            next_st.win1_out                  = 1'b0;
            next_st.trn_out                   = TRN_RST;
        end
        if (!FUNDAMENTAL_RESET_N) begin
            next_st                                 = '0;
            next_st.fast_train_count_separate_clock = FTS_SEP_RST;
            next_st.fast_train_count_shared_clock   = FTS_SHARED_RST;
            next_st.link_number                     = LINK_RST;
            next_st.link_out                        = LINK_RST;
            next_st.fts_out                         = FTS_SEP_RST;
        end
    end

    always_ff @(posedge CLOCK) begin
        st <= next_st;
    end

    // Ports straight from the registered copies
    assign FAST_TRAIN_COUNT             = st.fts_out;
    assign L2_POWER_SAVE                = st.l2_save_out;
    assign FIRST_BASE_WINDOW_ENABLE     = st.win0_out;
    assign SECOND_BASE_WINDOW_ENABLE    = st.win1_out;
    assign LINK_NUMBER                  = st.link_out;
    assign TRAINING_RECOVERY_REQUEST    = st.trn_out[TRN_RECOVERY_IDX];
    assign TRAINING_RECONFIGURE_REQUEST = st.trn_out[TRN_RECONFIG_IDX];
    assign HOT_RESET_REQUEST            = st.trn_out[TRN_HOT_RESET_IDX];
    assign SCRAMBLER_OFF_REQUEST        = st.trn_out[TRN_SCRAMBLER_IDX];
    assign TRAINING_LOOPBACK_REQUEST    = st.trn_out[TRN_LOOPBACK_IDX];

    // Checks on the register behaviour
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N || !FUNDAMENTAL_RESET_N);

    sequence s_write_low_byte;
        cfg.wr_en && cfg.wr_mask[0];
    endsequence

    sequence s_write_top_bytes;
        cfg.wr_en && cfg.wr_mask[24] && cfg.wr_mask[16];
    endsequence

    sequence s_write_link_byte;
        cfg.wr_en && cfg.wr_mask[8];
    endsequence

    property p_fts_separate;
        (!SHARED_REFCLK_CONFIG && !cfg.wr_en) ##1 !SHARED_REFCLK_CONFIG
            |=> FAST_TRAIN_COUNT == $past(st.fast_train_count_separate_clock, 2);
    endproperty
    a_fts_separate: assert property (p_fts_separate) else $error("separate-clock count not sent");

    property p_fts_shared;
        s_write_top_bytes ##1 SHARED_REFCLK_CONFIG |=> FAST_TRAIN_COUNT == $past(cfg.wr_data[23:16], 2);
    endproperty
    a_fts_shared: assert property (p_fts_shared) else $error("shared-clock count not sent");

    property p_l2_gate;
        !st.l2_power_saving_enable |=> !L2_POWER_SAVE;
    endproperty
    a_l2_gate: assert property (p_l2_gate) else $error("L2 savings applied while disabled");

    // Savings must actually follow the enable while the link sits in L2
    property p_l2_apply;
        st.l2_power_saving_enable && LINK_IN_L2 |=> L2_POWER_SAVE;
    endproperty
    a_l2_apply: assert property (p_l2_apply) else $error("L2 savings not applied while enabled");

    // Link number lands on its port two edges after the write
    property p_link_number;
        s_write_link_byte |-> ##2 LINK_NUMBER == $past(cfg.wr_data[LINK_LSB +: LINK_W], 2);
    endproperty
    a_link_number: assert property (p_link_number) else $error("link number not following write");

    property p_win1;
        s_write_low_byte |-> ##2 SECOND_BASE_WINDOW_ENABLE == $past(cfg.wr_data[WIN1_BIT], 2);
    endproperty
    a_win1: assert property (p_win1) else $error("second window enable not following write");

    property p_win0;
        s_write_low_byte |-> ##2 FIRST_BASE_WINDOW_ENABLE == $past(cfg.wr_data[WIN0_BIT], 2);
    endproperty
    a_win0: assert property (p_win0) else $error("first window enable not following write");

    property p_train_req;
        s_write_low_byte ##1 !cfg.wr_en
            |=> ({TRAINING_RECOVERY_REQUEST, TRAINING_RECONFIGURE_REQUEST, HOT_RESET_REQUEST,
                  SCRAMBLER_OFF_REQUEST, TRAINING_LOOPBACK_REQUEST} == $past(cfg.wr_data[4:0], 2))
                ##1 $stable({TRAINING_RECOVERY_REQUEST, TRAINING_RECONFIGURE_REQUEST, HOT_RESET_REQUEST,
                             SCRAMBLER_OFF_REQUEST, TRAINING_LOOPBACK_REQUEST});
    endproperty
    a_train_req: assert property (p_train_req) else $error("training requests not following write");

    property p_keep_on_plain_reset;
        disable iff (!FUNDAMENTAL_RESET_N)
        !RST_N |=> st.fast_train_count_separate_clock == $past(st.fast_train_count_separate_clock)
                   && st.link_number == $past(st.link_number);
    endproperty
    a_keep_on_plain_reset: assert property (p_keep_on_plain_reset) else $error("fundamental field lost");

    property p_fund_reset_values;
        disable iff (1'b0)
        !FUNDAMENTAL_RESET_N |=> cfg.reg_value == DIAG_TWO_RST && !SECOND_BASE_WINDOW_ENABLE;
    endproperty
    a_fund_reset_values: assert property (p_fund_reset_values) else $error("reset value wrong");

    property p_rev_read_only;
        cfg.rd_hit |=> CFG_ACK && CFG_RDATA[REV_LSB +: REV_W] == PHY_REVISION_FIELD_VALUE;
    endproperty
    a_rev_read_only: assert property (p_rev_read_only) else $error("revision field altered");
endmodule : pdc_top

// File: bench/pdc_link_model.sv
// Far side of the block: the rest of the bridge reporting link state
module pdc_link_model (
    // Clock
    input  wire logic       clock,
    // Link state the bench asks for
    input  wire logic [1:0] want,
    // Levels towards the block
    output logic            shared_refclk,
    output logic            in_l2
);
    timeunit 1ns;
    timeprecision 1ps;

    // Levels move just after an edge, like a registered source, so no race with the block
    initial begin
        shared_refclk = 1'b0;
        in_l2         = 1'b0;
        forever begin
            @(posedge clock);
            #1;
            shared_refclk = want[0];
            in_l2         = want[1];
        end
    end
endmodule : pdc_link_model

// File: bench/tb_top.sv
// Self-checking bench with a behavioural register image
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pdc_pkg::*;

    logic                  clock, rst_n, fundamental_reset_n_n, req, wr, ack, shared, in_l2, l2s, win0, win1;
    logic [CFG_ADDR_W-1:0] addr, ua;
    logic [3:0]            be;
    logic [31:0]           wdata, rdata, m;
    logic [1:0]            want;
    logic [FTS_W-1:0]      fts;
    logic [LINK_W-1:0]     link;
    wire  [4:0]            trn;
    int                    n_fail, checked;

    pdc_top dut_u (
        .CLOCK(clock), .RST_N(rst_n), .FUNDAMENTAL_RESET_N(fundamental_reset_n_n),
        .CFG_REQ(req), .CFG_WRITE(wr), .CFG_ADDR(addr), .CFG_BYTE_EN(be), .CFG_WDATA(wdata),
        .CFG_ACK(ack), .CFG_RDATA(rdata), .SHARED_REFCLK_CONFIG(shared), .LINK_IN_L2(in_l2),
        .FAST_TRAIN_COUNT(fts), .L2_POWER_SAVE(l2s), .FIRST_BASE_WINDOW_ENABLE(win0),
        .SECOND_BASE_WINDOW_ENABLE(win1), .LINK_NUMBER(link), .TRAINING_RECOVERY_REQUEST(trn[4]),
        .TRAINING_RECONFIGURE_REQUEST(trn[3]), .HOT_RESET_REQUEST(trn[2]),
        .SCRAMBLER_OFF_REQUEST(trn[1]), .TRAINING_LOOPBACK_REQUEST(trn[0])
    );

    pdc_link_model link_u (.clock(clock), .want(want), .shared_refclk(shared), .in_l2(in_l2));

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One access; updates the image and checks the answer; returns when steering shows it
    task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        logic [31:0] e;
        e = 32'h0000_0000;
        if (a[7:2] == DIAG_TWO_OFF[7:2]) begin
            if (w) begin
                for (int n = 0; n < 4; n++) if (b[n]) m[8*n+:8] = d[8*n+:8];
                m[15:13] = PHY_REVISION_FIELD_VALUE;
            end else begin
                e = m;
            end
        end
        req = 1'b1; wr = w; addr = a; be = b; wdata = d;
        @(posedge clock);
        #1;
        req = 1'b0;
        check({31'h0, ack}, 32'h0000_0001);
        check(rdata, e);
        @(posedge clock);
        #1;
    endtask : access

    // Steering outputs against the image, after the link levels have had time to land
    task automatic chk_out();
        repeat (3) @(posedge clock);
        #1;
        check(fts, shared ? m[23:16] : m[31:24]);
        check(l2s, m[7] & in_l2);
        check(win1, m[6]);
        check(win0, m[5]);
        check(trn, m[4:0]);
        check(link, m[12:8]);
    endtask : chk_out

    // One-edge reset pulse, ordinary or fundamental, then an idle edge
    task automatic pulse_reset(input logic fund);
        if (fund) fundamental_reset_n_n = 1'b0;
        else rst_n = 1'b0;
        @(posedge clock);
        #1;
        rst_n  = 1'b1;
        fundamental_reset_n_n = 1'b1;
        if (fund) m = DIAG_TWO_RST;
        else m[7:0] = 8'h00;
        @(posedge clock);
        #1;
    endtask : pulse_reset

    // Verdict in one place
    task automatic conclude();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        conclude();
    end

    initial begin
        rst_n = 1'b0; fundamental_reset_n_n = 1'b0; req = 1'b0; wr = 1'b0; addr = 8'h00; be = 4'h0;
        wdata = 32'h0000_0000; want = 2'h0; ua = 8'h00; m = DIAG_TWO_RST;
        n_fail = 0; checked = 0;
        void'($urandom(81));
        repeat (12) @(posedge clock);
        #1;
        rst_n  = 1'b1;
        fundamental_reset_n_n = 1'b1;
        @(posedge clock);
        #1;
        // Power-up image and both count selections
        access(1'b0, 8'hC8, 4'hF, 32'h0000_0000);
        chk_out();
        want = 2'h1;
        chk_out();
        $display("test reset values done");
        // Each training request alone
        for (int i = 0; i < 5; i++) begin
            access(1'b1, 8'hC8, 4'h1, 32'h0000_0001 << i);
            chk_out();
        end
        $display("test training requests done");
        // Random data, lanes, byte address inside the dword and link state
        repeat (40) begin
            want = 2'($urandom);
            access(1'b1, 8'hC8 + 8'($urandom_range(3)), 4'($urandom), $urandom);
            access(1'b0, 8'hC8 + 8'($urandom_range(3)), 4'($urandom), 32'h0000_0000);
            chk_out();
        end
        $display("test random access done");
        // Unmapped places are acked, ignore writes and read zero
        repeat (10) begin
            ua = 8'($urandom);
            if (ua[7:2] == DIAG_TWO_OFF[7:2]) ua = ua ^ 8'h40;
            access(1'b1, ua, 4'hF, $urandom);
            access(1'b0, ua, 4'hF, 32'h0000_0000);
        end
        access(1'b0, 8'hC8, 4'hF, 32'h0000_0000);
        $display("test unmapped access done");
        // Ordinary reset keeps fundamental-only fields
        access(1'b1, 8'hC8, 4'hF, 32'hFFFF_FFFF);
        pulse_reset(1'b0);
        access(1'b0, 8'hC8, 4'hF, 32'h0000_0000);
        chk_out();
        // Fundamental reset returns every field to its default, where software should leave it
        pulse_reset(1'b1);
        access(1'b0, 8'hC8, 4'hF, 32'h0000_0000);
        chk_out();
        $display("test resets done");
        conclude();
    end
endmodule : tb_top
